// ### logic/dtcp_pkg.sv
// Purpose: shared constants and types for the dual timer, capture and pwm
// Assumes: 8-bit registers held in the low byte of aligned 32-bit words
// Notes:   offsets are byte addresses on the register bus
package dtcp_pkg;
    localparam int          AddrW      = 6;
    // register byte offsets
    localparam logic [5:0]  OffCtrl0   = 6'h00;
    localparam logic [5:0]  OffCtrl1   = 6'h04;
    localparam logic [5:0]  OffMatch0  = 6'h08;
    localparam logic [5:0]  OffMatch1  = 6'h0c;
    localparam logic [5:0]  OffPwmHigh = 6'h10;
    localparam logic [5:0]  OffDutyA   = 6'h14;
    localparam logic [5:0]  OffDutyB   = 6'h18;
    localparam logic [5:0]  OffDutyC   = 6'h1c;
    localparam logic [5:0]  OffCtrl3   = 6'h20;
    localparam logic [5:0]  OffStatus  = 6'h24;
    // field positions
    localparam int          PosSel0    = 0;   // ctrl0 [2:0]
    localparam int          PosCapEn0  = 3;   // ctrl0
    localparam int          PosCascade = 4;   // ctrl0
    localparam int          PosSel1    = 0;   // ctrl1 [3:0]
    localparam int          PosCapEn1  = 4;   // ctrl1
    localparam int          PosPwmEn   = 5;   // ctrl1
    localparam int          PosPol     = 0;   // ctrl3 [2:0]
    localparam int          PosPortEn  = 4;   // ctrl3 [5:4]
    // reset values
    localparam logic [7:0]  RstCtrl    = 8'h00;
    localparam logic [7:0]  RstMatch   = 8'hff;
    localparam logic [7:0]  RstPeriod  = 8'hff;
    localparam logic [7:0]  RstDuty    = 8'h7f;
    localparam logic [7:0]  RstHigh    = 8'h00;
    // selector codes and timing
    localparam logic [2:0]  Sel0Event  = 3'h7;
    localparam logic [3:0]  Sel1Chain  = 4'hf;
    localparam int          PreW       = 14;  // divide up to 16384
    localparam logic [1:0]  RespOkay   = 2'h0;
    localparam logic [1:0]  RespSlvErr = 2'h2;

    typedef struct packed {
        logic       cascade;
        logic       capEn0;
        logic       capEn1;
        logic       pwmEn;
        logic [2:0] sel0;
        logic [3:0] sel1;
        logic [1:0] portEn;   // [1] timer0 pin, [0] timer1 pin
        logic [2:0] pol;
    } dtcp_cfg_t;
endpackage

// ### logic/dtcp_top.sv
// Purpose: two 8-bit timers, cascadable, with capture, compare and pwm
// Assumes: AXI4-Lite register access, pins synchronised inside
// Notes:   counters advance on prescaler taps of clk_sys or event edges
//
// Notes on behaviour
// R01: two independent 8-bit counters, or one cascaded 16-bit counter
// R02: software keeps each match value above 0x03
// R03: timer0 select picks divide 2,4,8,32,128,512,2048 or event input
// R04: timer1 select picks divide 1 to 16384 or timer0 clock
// R05: timer1 is never clocked straight from the event input
// R06: event source counts rising edges and forces its pin to input
// R07: in 8-bit mode each timer flags when count equals its match value
// R08: mode decoded from cascade, captures, pwm, selects and port enables
// R09: cascaded counter counts up to combined match value then returns to zero
// R10: cascaded match raises only the timer0 event, never timer1
// R11: cascade needs select 1111; timer0 low byte, timer1 high byte
// R12: software keeps low match byte nonzero in cascade mode
// R13: capture edge stores the count, then clears counter and restarts
// R14: in capture mode the match event still fires
// R15: in capture mode the shared read address returns the capture value
// R16: cascaded capture stores and clears the full 16-bit counter
// R17: pwm enable makes timer1 drive six pins at up to 10 bits
// R18: pwm period is two high bits above the 8-bit period register
// R19: channel A duty uses high bits 7:6 above its duty register
// R20: software keeps pwm period above the duty values
// R21: polarity bit fixes level at duty equal period and duty zero
// R22: timer0 drives compare pin; timer1 its result or six pwm pins
// R23: compare match toggles output, exported only with timer1 port enable
// R24: channels B and C take high bits 5:4 and 3:2
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module dtcp_top #(
    parameter int PreW = dtcp_pkg::PreW  // prescaler width
) (
    input  wire logic        clk_sys,          // 125 MHz system clock
    input  wire logic        arst_n,           // async reset, low active
    input  wire logic [5:0]  s_axi_awaddr,     // write address
    input  wire logic        s_axi_awvalid,    // write address valid
    output logic             s_axi_awready,    // write address ready
    input  wire logic [31:0] s_axi_wdata,      // write data
    input  wire logic [3:0]  s_axi_wstrb,      // byte enables
    input  wire logic        s_axi_wvalid,     // write data valid
    output logic             s_axi_wready,     // write data ready
    output logic [1:0]       s_axi_bresp,      // write response
    output logic             s_axi_bvalid,     // write response valid
    input  wire logic        s_axi_bready,     // write response ready
    input  wire logic [5:0]  s_axi_araddr,     // read address
    input  wire logic        s_axi_arvalid,    // read address valid
    output logic             s_axi_arready,    // read address ready
    output logic [31:0]      s_axi_rdata,      // read data
    output logic [1:0]       s_axi_rresp,      // read response
    output logic             s_axi_rvalid,     // read data valid
    input  wire logic        s_axi_rready,     // read data ready
    input  wire logic        eventClockPin,    // external event input
    input  wire logic        captureInputA,    // capture trigger timer0
    input  wire logic        captureInputB,    // capture trigger timer1
    output logic             eventPinInput,    // event pin forced input
    output logic             firstTimerOut,    // timer0 compare pin
    output logic             firstTimerOe,     // timer0 pin enable
    output logic [5:0]       pwmPinOut,        // A,AB,B,BB,C,CB
    output logic [5:0]       pwmPinOe,         // pwm pin enables
    output logic             firstMatchIrq,    // timer0 match pulse
    output logic             secondMatchIrq    // timer1 match pulse
);
    // reset release through two flops
    logic [1:0] rstSync_reg;
    logic       rstN;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) rstSync_reg <= 2'h0;
        else         rstSync_reg <= {rstSync_reg[0], 1'b1};
    end
    assign rstN = rstSync_reg[1];

    // register storage
    logic [7:0] ctrl0_reg, ctrl1_reg, ctrl3_reg, match0_reg, match1_reg;
    logic [7:0] period_reg, high_reg;
    logic [7:0] duty_reg [3];
    logic [3:0] status_reg;
    dtcp_pkg::dtcp_cfg_t cfg;

    // configuration view, mode decode
    assign cfg.cascade = ctrl0_reg[dtcp_pkg::PosCascade];
    assign cfg.capEn0  = ctrl0_reg[dtcp_pkg::PosCapEn0];
    assign cfg.sel0    = ctrl0_reg[dtcp_pkg::PosSel0 +: 3];
    assign cfg.sel1    = ctrl1_reg[dtcp_pkg::PosSel1 +: 4];
    assign cfg.capEn1  = ctrl1_reg[dtcp_pkg::PosCapEn1];
    assign cfg.pwmEn   = ctrl1_reg[dtcp_pkg::PosPwmEn];
    assign cfg.pol     = ctrl3_reg[dtcp_pkg::PosPol +: 3];
    assign cfg.portEn  = ctrl3_reg[dtcp_pkg::PosPortEn +: 2];

    logic cascadeOn;
    assign cascadeOn = cfg.cascade && (cfg.sel1 == dtcp_pkg::Sel1Chain); // R08 R11

    // pin synchronisers plus edge stage
    logic [2:0] evtSync_reg, capASync_reg, capBSync_reg;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            evtSync_reg  <= 3'h0;
            capASync_reg <= 3'h0;
            capBSync_reg <= 3'h0;
        end else begin
            evtSync_reg  <= {evtSync_reg[1:0], eventClockPin};
            capASync_reg <= {capASync_reg[1:0], captureInputA};
            capBSync_reg <= {capBSync_reg[1:0], captureInputB};
        end
    end
    logic evtRise, capRiseA, capRiseB;
    assign evtRise  = evtSync_reg[1] && !evtSync_reg[2];  // R06
    assign capRiseA = capASync_reg[1] && !capASync_reg[2];
    assign capRiseB = capBSync_reg[1] && !capBSync_reg[2];

    // free running prescaler and its taps
    logic [PreW-1:0] pre_reg;
    logic [PreW:0]   preTick;
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) pre_reg <= '0;
        else       pre_reg <= pre_reg + 1'b1;
    end
    assign preTick[0] = 1'b1;
    for (genvar i = 1; i <= PreW; i++) begin : g_tap
        assign preTick[i] = &pre_reg[i-1:0];
    end

    // clock source selection
    logic tick0, tick1;
    always_comb begin
        case (cfg.sel0)                                // R03
            3'h0:    tick0 = preTick[1];
            3'h1:    tick0 = preTick[2];
            3'h2:    tick0 = preTick[3];
            3'h3:    tick0 = preTick[5];
            3'h4:    tick0 = preTick[7];
            3'h5:    tick0 = preTick[9];
            3'h6:    tick0 = preTick[11];
            default: tick0 = evtRise;                  // R06
        endcase
        // timer1 has no event path, code 1111 follows timer0
        if (cfg.sel1 == dtcp_pkg::Sel1Chain) tick1 = tick0; // R04 R05
        else                                 tick1 = preTick[cfg.sel1];
    end

    // counters, matches and captures
    logic [7:0]  cnt0_reg, cnt1_reg, first_capture_enable_reg, second_capture_enable_reg;
    logic [15:0] cnt16, match16;
    logic        hit0, hit1, capTake0, capTake1;
    assign cnt16    = {cnt1_reg, cnt0_reg};
    assign match16  = {match1_reg, match0_reg};
    assign capTake0 = cfg.capEn0 && capRiseA;
    assign capTake1 = !cascadeOn && cfg.capEn1 && capRiseB;
    assign hit0 = tick0 && !capTake0 &&
                  (cascadeOn ? (cnt16 == match16) : (cnt0_reg == match0_reg));
    assign hit1 = !cascadeOn && !cfg.pwmEn && tick1 && !capTake1 &&
                  (cnt1_reg == match1_reg);   // R07 R10 R14

    // counter update
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            cnt0_reg <= 8'h00;
            cnt1_reg <= 8'h00;
        end else if (cascadeOn) begin
            if (capTake0) begin
                cnt0_reg <= 8'h00;                     // R16
                cnt1_reg <= 8'h00;
            end else if (hit0) begin
                cnt0_reg <= 8'h00;                     // R09
                cnt1_reg <= 8'h00;
            end else if (tick0) begin
                cnt0_reg <= cnt0_reg + 8'h01;          // R11
                if (cnt0_reg == 8'hff) cnt1_reg <= cnt1_reg + 8'h01;
            end
        end else begin
            if (capTake0)  cnt0_reg <= 8'h00;          // R13
            else if (hit0) cnt0_reg <= 8'h00;          // R01
            else if (tick0) cnt0_reg <= cnt0_reg + 8'h01;
            if (capTake1 || cfg.pwmEn) cnt1_reg <= 8'h00;
            else if (hit1)  cnt1_reg <= 8'h00;
            else if (tick1) cnt1_reg <= cnt1_reg + 8'h01;
        end
    end

    // capture registers
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            first_capture_enable_reg <= 8'h00;
            second_capture_enable_reg <= 8'h00;
        end else begin
            if (capTake0) first_capture_enable_reg <= cnt0_reg;        // R13
            if (capTake0 && cascadeOn) second_capture_enable_reg <= cnt1_reg; // R16
            else if (capTake1) second_capture_enable_reg <= cnt1_reg;
        end
    end

    // match pulses and compare toggles
    logic cmp0_reg, cmp1_reg;
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            firstMatchIrq  <= 1'b0;
            secondMatchIrq <= 1'b0;
            cmp0_reg       <= 1'b0;
            cmp1_reg       <= 1'b0;
        end else begin
            firstMatchIrq  <= hit0;                    // R07
            secondMatchIrq <= hit1;                    // R10
            if (hit0) cmp0_reg <= !cmp0_reg;
            if (hit1 || (cascadeOn && hit0)) cmp1_reg <= !cmp1_reg; // R23
        end
    end

    // pwm counter, period and duties
    logic [9:0] pwmCnt_reg, period10, pwmCntInc;
    logic [9:0] duty10 [3];
    logic [2:0] level;
    assign period10  = {high_reg[1:0], period_reg};    // R18
    assign pwmCntInc = pwmCnt_reg + 10'h001;
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN)                pwmCnt_reg <= 10'h000;
        else if (!cfg.pwmEn)      pwmCnt_reg <= 10'h000;
        else if (tick1)
            pwmCnt_reg <= (pwmCntInc >= period10) ? 10'h000 : pwmCntInc;
    end
    for (genvar c = 0; c < 3; c++) begin : g_ch
        // A uses 7:6, B 5:4, C 3:2
        assign duty10[c] = {high_reg[7-2*c -: 2], duty_reg[c]}; // R19 R24
        assign level[c]  = cfg.pol[c] ? (pwmCnt_reg < duty10[c])
                                      : !(pwmCnt_reg < duty10[c]); // R21
    end

    // pin drivers
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            eventPinInput <= 1'b0;
            firstTimerOut <= 1'b0;
            firstTimerOe  <= 1'b0;
            pwmPinOut     <= 6'h00;
            pwmPinOe      <= 6'h00;
        end else begin
            eventPinInput <= (cfg.sel0 == dtcp_pkg::Sel0Event); // R06
            firstTimerOut <= cmp0_reg;                         // R22
            firstTimerOe  <= cfg.portEn[1] && !cfg.capEn0;
            if (cfg.pwmEn) begin
                pwmPinOut <= {!level[2], level[2], !level[1], level[1],
                              !level[0], level[0]};            // R17 R22
                pwmPinOe  <= {6{cfg.portEn == 2'h3}};          // R08
            end else begin
                pwmPinOut <= {5'h00, cmp1_reg};                // R22
                pwmPinOe  <= {5'h00, cfg.portEn[0]};           // R23
            end
        end
    end

    // AXI write channel
    logic [5:0]  awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0]  wStrb_reg;
    logic        awHave_reg, wHave_reg, doWrite, wrHit, lane0;
    assign doWrite = awHave_reg && wHave_reg && !s_axi_bvalid;
    assign lane0   = wStrb_reg[0];
    assign wrHit   = (awAddr_reg <= dtcp_pkg::OffStatus) &&
                     (awAddr_reg[1:0] == 2'h0);
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            awHave_reg <= 1'b0;
            wHave_reg  <= 1'b0;
            awAddr_reg <= 6'h00;
            wData_reg  <= 32'h0;
            wStrb_reg  <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= dtcp_pkg::RespOkay;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= doWrite ||
                             !(awHave_reg || (s_axi_awvalid && s_axi_awready));
            s_axi_wready  <= doWrite ||
                             !(wHave_reg || (s_axi_wvalid && s_axi_wready));
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_reg <= 1'b1;
                awAddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHave_reg   <= 1'b0;
                wHave_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrHit ? dtcp_pkg::RespOkay
                                      : dtcp_pkg::RespSlvErr;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register writes
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            ctrl0_reg  <= dtcp_pkg::RstCtrl;
            ctrl1_reg  <= dtcp_pkg::RstCtrl;
            ctrl3_reg  <= dtcp_pkg::RstCtrl;
            match0_reg <= dtcp_pkg::RstMatch;
            match1_reg <= dtcp_pkg::RstMatch;
            period_reg <= dtcp_pkg::RstPeriod;
            high_reg   <= dtcp_pkg::RstHigh;
            duty_reg   <= '{dtcp_pkg::RstDuty, dtcp_pkg::RstDuty,
                            dtcp_pkg::RstDuty};
        end else if (doWrite && lane0) begin
            if (awAddr_reg == dtcp_pkg::OffCtrl0)
                ctrl0_reg <= wData_reg[7:0];
            else if (awAddr_reg == dtcp_pkg::OffCtrl1)
                ctrl1_reg <= wData_reg[7:0];
            else if (awAddr_reg == dtcp_pkg::OffMatch0)
                match0_reg <= wData_reg[7:0];
            else if (awAddr_reg == dtcp_pkg::OffMatch1) begin
                // shared address: period in pwm mode, match otherwise
                if (cfg.pwmEn) period_reg <= wData_reg[7:0];
                else           match1_reg <= wData_reg[7:0];
            end else if (awAddr_reg == dtcp_pkg::OffPwmHigh)
                high_reg <= wData_reg[7:0];
            else if (awAddr_reg == dtcp_pkg::OffDutyA)
                duty_reg[0] <= wData_reg[7:0];
            else if (awAddr_reg == dtcp_pkg::OffDutyB)
                duty_reg[1] <= wData_reg[7:0];
            else if (awAddr_reg == dtcp_pkg::OffDutyC)
                duty_reg[2] <= wData_reg[7:0];
            else if (awAddr_reg == dtcp_pkg::OffCtrl3)
                ctrl3_reg <= wData_reg[7:0];
        end
    end

    // sticky event flags, set wins over write-one clear
    logic [3:0] setFlags, clrFlags;
    assign setFlags = {capTake1 || (capTake0 && cascadeOn), capTake0,
                       hit1, hit0};
    assign clrFlags = (doWrite && lane0 &&
                       awAddr_reg == dtcp_pkg::OffStatus) ?
                      wData_reg[3:0] : 4'h0;
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) status_reg <= 4'h0;
        else       status_reg <= (status_reg & ~clrFlags) | setFlags;
    end

    // AXI read channel
    logic [7:0] rdByte;
    logic       rdHit;
    always_comb begin
        rdByte = 8'h00;
        rdHit  = 1'b1;
        if (s_axi_araddr == dtcp_pkg::OffCtrl0)       rdByte = ctrl0_reg;
        else if (s_axi_araddr == dtcp_pkg::OffCtrl1)  rdByte = ctrl1_reg;
        else if (s_axi_araddr == dtcp_pkg::OffMatch0)
            rdByte = cfg.capEn0 ? first_capture_enable_reg : cnt0_reg;           // R15
        else if (s_axi_araddr == dtcp_pkg::OffMatch1)
            rdByte = (cfg.capEn1 || (cascadeOn && cfg.capEn0)) ?
                     second_capture_enable_reg : cnt1_reg;                        // R15
        else if (s_axi_araddr == dtcp_pkg::OffPwmHigh) rdByte = high_reg;
        else if (s_axi_araddr == dtcp_pkg::OffDutyA)  rdByte = duty_reg[0];
        else if (s_axi_araddr == dtcp_pkg::OffDutyB)  rdByte = duty_reg[1];
        else if (s_axi_araddr == dtcp_pkg::OffDutyC)  rdByte = duty_reg[2];
        else if (s_axi_araddr == dtcp_pkg::OffCtrl3)  rdByte = ctrl3_reg;
        else if (s_axi_araddr == dtcp_pkg::OffStatus)
            rdByte = {4'h0, status_reg};
        else rdHit = 1'b0;
    end
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= dtcp_pkg::RespOkay;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h0, rdByte};
                s_axi_rresp  <= rdHit ? dtcp_pkg::RespOkay
                                      : dtcp_pkg::RespSlvErr;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // checks
    sequence s_capture;
        capTake0 && !cascadeOn;
    endsequence
    property p_r13;
        @(posedge clk_sys) disable iff (!rstN)
        s_capture |=> (cnt0_reg == 8'h00) && (first_capture_enable_reg == $past(cnt0_reg));
    endproperty
    a_r13: assert property (p_r13) else $error("capture missed"); // R13
    property p_r07;
        @(posedge clk_sys) disable iff (!rstN)
        (!cascadeOn && tick0 && !capTake0 && cnt0_reg == match0_reg)
        |=> firstMatchIrq && cnt0_reg == 8'h00;
    endproperty
    a_r07: assert property (p_r07) else $error("timer0 match lost"); // R07
    property p_r10;
        @(posedge clk_sys) disable iff (!rstN)
        secondMatchIrq |-> !$past(cascadeOn);
    endproperty
    a_r10: assert property (p_r10) else $error("timer1 event in cascade"); // R10
    property p_r09;
        @(posedge clk_sys) disable iff (!rstN)
        (cascadeOn && hit0) |=> cnt16 == 16'h0000 ##0 firstMatchIrq;
    endproperty
    a_r09: assert property (p_r09) else $error("cascade wrap wrong"); // R09
    property p_r06;
        @(posedge clk_sys) disable iff (!rstN)
        (cfg.sel0 == dtcp_pkg::Sel0Event)[*2] |-> eventPinInput;
    endproperty
    a_r06: assert property (p_r06) else $error("event pin not input"); // R06
    property p_r05;
        @(posedge clk_sys) disable iff (!rstN)
        (cfg.sel1 != dtcp_pkg::Sel1Chain) |-> tick1 == preTick[cfg.sel1];
    endproperty
    a_r05: assert property (p_r05) else $error("timer1 source wrong"); // R05
    property p_r21;
        @(posedge clk_sys) disable iff (!rstN)
        (cfg.pwmEn && duty10[1] == period10 && period10 != 10'h000)
        |=> pwmPinOut[2] == $past(cfg.pol[1]);
    endproperty
    a_r21: assert property (p_r21) else $error("pwm level wrong"); // R21
    property p_r23;
        @(posedge clk_sys) disable iff (!rstN)
        hit1 |=> cmp1_reg != $past(cmp1_reg) ##1 pwmPinOut[0] == cmp1_reg;
    endproperty
    a_r23: assert property (p_r23) else $error("compare toggle lost"); // R23
    property p_r15;
        @(posedge clk_sys) disable iff (!rstN)
        (s_axi_arvalid && s_axi_arready && cfg.capEn0 &&
         s_axi_araddr == dtcp_pkg::OffMatch0)
        |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(first_capture_enable_reg);
    endproperty
    a_r15: assert property (p_r15) else $error("capture read wrong"); // R15
endmodule // dtcp_top
`default_nettype wire

// ### test/dtcp_pin_model.sv
// Purpose: far side pins, event clock and capture triggers
// Assumes: pins rest low outside pulses
// Notes:   each level held 4 cycles to pass the synchronisers
`timescale 1ns/1ns
`default_nettype none
module dtcp_pin_model (
    input  wire logic clk_sys,       // system clock
    output var  logic eventClockPin, // counted edges
    output var  logic captureInputA, // capture trigger a
    output var  logic captureInputB  // capture trigger b
);
    // pins idle low
    initial begin
        eventClockPin = 1'b0;
        captureInputA = 1'b0;
        captureInputB = 1'b0;
    end
    // n rising edges on the event pin
    task automatic pulse_event(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk_sys) eventClockPin <= 1'b1;
            repeat (4) @(posedge clk_sys) eventClockPin <= 1'b0;
        end
    endtask
    // one rising edge on capture pin a
    task automatic pulse_capture();
        repeat (4) @(posedge clk_sys) captureInputA <= 1'b1;
        repeat (4) @(posedge clk_sys) captureInputA <= 1'b0;
    endtask
endmodule // dtcp_pin_model
`default_nettype wire

// ### test/test_dual_timer_capture_pwm.sv
// Purpose: self-checking bench for the dual timer, capture and pwm
// Assumes: reads compared by a watcher draining a queue of notes
// Notes:   match above 3 kept by the bench, pwm duty B set equal to period
`timescale 1ns/1ns
`default_nettype none
module test_dual_timer_capture_pwm;
    logic        clk_sys = 1'b0, arst_n = 1'b0;
    logic [5:0]  s_axi_awaddr = '0, s_axi_araddr = '0, pwmPinOut, pwmPinOe;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h1;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, eventClockPin;
    logic        captureInputA, captureInputB, eventPinInput, firstTimerOut;
    logic        firstTimerOe, firstMatchIrq, secondMatchIrq;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [33:0] expq[$];
    int          failures = 0, samples_checked = 0;
    // clock, device and far side
    always #4 clk_sys = ~clk_sys;
    dtcp_top #(.PreW(14)) dut (.clk_sys, .arst_n, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .eventClockPin, .captureInputA, .captureInputB, .eventPinInput,
        .firstTimerOut, .firstTimerOe, .pwmPinOut, .pwmPinOe,
        .firstMatchIrq, .secondMatchIrq);
    dtcp_pin_model pins (.clk_sys, .eventClockPin, .captureInputA,
        .captureInputB);
    // compare and count
    task automatic check(input string nm, input logic [33:0] x, g);
        samples_checked++;
        if (g !== x) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, x, g);
        end
    endtask
    // counts, verdict, end of run
    task automatic conclude();
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one register access, write or read
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [33:0] x);
        logic ta, tw, tr;
        int   n;
        @(posedge clk_sys);
        if (!w) expq.push_back(x);
        s_axi_awaddr  <= a;
        s_axi_araddr  <= a;
        s_axi_wdata   <= {24'($urandom()), x[7:0]};
        s_axi_awvalid <= w;
        s_axi_wvalid  <= w;
        s_axi_bready  <= w;
        s_axi_arvalid <= !w;
        s_axi_rready  <= !w;
        tr = 1'b0;
        for (n = 0; n < 40 && !tr; n++) begin
            @(negedge clk_sys);
            ta = w ? s_axi_awready : s_axi_arready;
            tw = s_axi_wready;
            tr = w ? s_axi_bvalid : s_axi_rvalid;
            @(posedge clk_sys);
            if (ta) s_axi_awvalid <= 1'b0;
            if (ta) s_axi_arvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tr) s_axi_bready <= 1'b0;
            if (tr) s_axi_rready <= 1'b0;
        end
        if (!tr) begin
            failures++;
            conclude();
        end
    endtask
    // cycles between timer0 pulses, timer1 pulses counted meanwhile
    task automatic gap(input int x, input logic quiet);
        int n, c, s;
        for (n = 0; n < 2100 && firstMatchIrq !== 1'b1; n++)
            @(negedge clk_sys);
        c = 0;
        s = 0;
        do begin
            @(negedge clk_sys);
            c++;
            if (secondMatchIrq !== 1'b0) s++;
        end while (firstMatchIrq !== 1'b1 && c < 2100);
        check("gap", 34'(x), 34'(c));
        if (quiet) check("irq1", 34'h0, 34'(s));
        if (c >= 2100) conclude();
    endtask
    // read data against the oldest note
    always @(posedge clk_sys) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready)
            check("rdata", expq.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid === 1'b1 && s_axi_bready)
            check("bresp", 34'h0, 34'(s_axi_bresp));
    end
    // reset, then scenarios
    initial begin
        void'($urandom(3506));
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        bus(1'b0, 6'h00, {dtcp_pkg::RespOkay, 32'h0});
        bus(1'b0, 6'h14, {dtcp_pkg::RespOkay, 24'h0, dtcp_pkg::RstDuty});
        bus(1'b0, 6'h3c, {dtcp_pkg::RespSlvErr, 32'h0});
        bus(1'b1, 6'h0c, 34'h04);
        bus(1'b1, 6'h08, 34'h04);
        gap(10, 1'b0);
        bus(1'b1, 6'h00, 34'h07);
        repeat (6) @(negedge clk_sys);
        check("evin", 34'h1, 34'(eventPinInput));
        fork
            pins.pulse_event(12);
            gap(40, 1'b0);
        join
        bus(1'b1, 6'h0c, 34'h04);
        bus(1'b1, 6'h04, 34'h0f);
        bus(1'b1, 6'h00, 34'h10);
        gap(2058, 1'b1);
        bus(1'b1, 6'h08, 34'hf0);
        bus(1'b1, 6'h00, 34'h0f);
        pins.pulse_capture();
        pins.pulse_event(3);
        pins.pulse_capture();
        bus(1'b0, 6'h08, {dtcp_pkg::RespOkay, 32'h3});
        bus(1'b1, 6'h04, 34'h20);
        bus(1'b1, 6'h0c, 34'hff);
        bus(1'b1, 6'h14, 34'h00);
        bus(1'b1, 6'h18, 34'hff);
        bus(1'b1, 6'h20, 34'h33);
        repeat (300) begin
            @(negedge clk_sys);
            check("pwm", 34'h2, 34'({pwmPinOut[2], pwmPinOut[0]}));
        end
        check("pwmoe", 34'h3f, 34'(pwmPinOe));
        conclude();
    end
endmodule // test_dual_timer_capture_pwm
`default_nettype wire
